// ### rtl/rps_pkg.sv
// constants for the four-rail power sequencer
// What this block does
// - rails power up at their up-slot
// - rails power down at their down-slot
// - first up strobe after power-good plus delay
// - up strobe spacing 3/6/9/12 ms
// - down strobe spacing 6/12/24/48 ms
// - first down strobe 3 or 6 ms
// - down spacing scaled 1x or 16x
package rps_pkg;
  // ****************************************
  // register indices, byte address is four times
  // ****************************************
  localparam logic [7:0] IDX_UP_ORDER = 8'h09;
  localparam logic [7:0] IDX_UP_DELAYS = 8'h0a;
  localparam logic [7:0] IDX_DN_ORDER = 8'h0b;
  localparam logic [7:0] IDX_DN_DELAYS = 8'h0c;
  localparam logic [7:0] IDX_STATUS = 8'h10;
  localparam int ADDR_IDX_LSB = 2;
  localparam int ADDR_IDX_W = 8;
  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] RST_UP_ORDER = 8'he4;
  localparam logic [7:0] RST_UP_DELAYS = 8'h55;
  localparam logic [7:0] RST_DN_ORDER = 8'h1e;
  localparam logic [7:0] RST_DN_DELAYS = 8'he0;
  // ****************************************
  // field positions
  // ****************************************
  localparam int DN_FIRST_BIT = 1;
  localparam int DN_MULT_BIT = 0;
  localparam int ST_RAIL_LSB = 0;
  localparam int ST_SLOT_LSB = 4;
  localparam int ST_STATE_LSB = 8;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int MS_NS = 1000000;
  localparam logic [9:0] UP_STEP_MS = 10'h003;
  localparam logic [9:0] DN_BASE_MS = 10'h006;
  localparam logic [9:0] DN_FIRST_LO_MS = 10'h003;
  localparam logic [9:0] DN_FIRST_HI_MS = 10'h006;
  localparam int DN_MULT_SHIFT = 4;
  localparam logic [1:0] LAST_SLOT = 2'h3;
  // ****************************************
  // sequencer states
  // ****************************************
  typedef enum logic [3:0] {
    RPS_OFF = 4'h1,
    RPS_UP = 4'h2,
    RPS_ON = 4'h4,
    RPS_DN = 4'h8
  } rps_state_t;
endpackage

// ### rtl/rps_sequencer.sv
// four-rail power sequencer with AHB-Lite register slave
//
// The AHB-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module rps_sequencer #(
  parameter int CYC_PER_MS = rps_pkg::MS_NS / rps_pkg::CLK_PERIOD_NS
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // sequence triggers
  input wire logic negative_converter_power_good,
  input wire logic wake_request,
  // rail enables
  output logic high_gate_rail,
  output logic positive_source_rail,
  output logic low_gate_rail,
  output logic negative_source_rail,
  // slot strobes
  output logic sequence_slot_one,
  output logic sequence_slot_two,
  output logic sequence_slot_three,
  output logic sequence_slot_four
);
  localparam int PW = (CYC_PER_MS > 1) ? $clog2(CYC_PER_MS) : 1;

  // ****************************************
  // delay lookup
  // ****************************************
  function automatic logic [9:0] dly_ms(input logic up, input logic [1:0] s,
                                        input logic [7:0] ur,
                                        input logic [7:0] dr);
    logic [1:0] c;
    logic [9:0] b;
    c = up ? ur[{s, 1'b0} +: 2] : dr[{s, 1'b0} +: 2];
    b = rps_pkg::DN_BASE_MS;
    if (up) begin
      b = 10'(rps_pkg::UP_STEP_MS * (10'(c) + 10'h001));
    end else if (s == 2'h0) begin
      b = dr[rps_pkg::DN_FIRST_BIT] ? rps_pkg::DN_FIRST_HI_MS
                                    : rps_pkg::DN_FIRST_LO_MS;
    end else begin
      b = rps_pkg::DN_BASE_MS << c;
      if (dr[rps_pkg::DN_MULT_BIT]) begin
        b = b << rps_pkg::DN_MULT_SHIFT;
      end
    end
    return b;
  endfunction

  // ****************************************
  // registers and state
  // ****************************************
  logic [7:0] up_order_q, up_dly_q, dn_order_q, dn_dly_q;
  rps_pkg::rps_state_t st_q, st_d;
  logic [1:0] slot_q, slot_d;
  logic [9:0] ms_q;
  logic [PW-1:0] pre_q;
  logic [3:0] rail_q, rail_d, strobe_q;
  logic pg_q;
  logic wr_q;
  localparam int ADDR_IDX_W_L = rps_pkg::ADDR_IDX_W;
  logic [ADDR_IDX_W_L-1:0] widx_q;
  logic [31:0] hrdata_q;

  // ****************************************
  // bus decode
  // ****************************************
  wire addr_ok = hsel & htrans[1] & hready;
  wire [ADDR_IDX_W_L-1:0] ridx = haddr[rps_pkg::ADDR_IDX_LSB +: ADDR_IDX_W_L];
  wire [31:0] status_w = {20'h00000, st_q, 2'h0, slot_q, rail_q};
  wire [31:0] rd_val =
    (ridx == rps_pkg::IDX_UP_ORDER) ? {24'h000000, up_order_q} :
    (ridx == rps_pkg::IDX_UP_DELAYS) ? {24'h000000, up_dly_q} :
    (ridx == rps_pkg::IDX_DN_ORDER) ? {24'h000000, dn_order_q} :
    (ridx == rps_pkg::IDX_DN_DELAYS) ? {24'h000000, dn_dly_q} :
    (ridx == rps_pkg::IDX_STATUS) ? status_w : 32'h00000000;
  wire we_uo = wr_q & (widx_q == rps_pkg::IDX_UP_ORDER);
  wire we_ud = wr_q & (widx_q == rps_pkg::IDX_UP_DELAYS);
  wire we_do = wr_q & (widx_q == rps_pkg::IDX_DN_ORDER);
  wire we_dd = wr_q & (widx_q == rps_pkg::IDX_DN_DELAYS);
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_q <= 1'b0;
      widx_q <= '0;
      hrdata_q <= 32'h00000000;
    end else begin
      wr_q <= addr_ok & hwrite;
      widx_q <= ridx;
      if (addr_ok & ~hwrite) begin
        hrdata_q <= rd_val;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      up_order_q <= rps_pkg::RST_UP_ORDER;
      up_dly_q <= rps_pkg::RST_UP_DELAYS;
      dn_order_q <= rps_pkg::RST_DN_ORDER;
      dn_dly_q <= rps_pkg::RST_DN_DELAYS;
    end else begin
      if (we_uo) up_order_q <= hwdata[7:0];
      if (we_ud) up_dly_q <= hwdata[7:0];
      if (we_do) dn_order_q <= hwdata[7:0];
      if (we_dd) dn_dly_q <= hwdata[7:0];
    end
  end

  // ****************************************
  // slot matching
  // ****************************************
  wire pg_rise = negative_converter_power_good & ~pg_q;
  wire ms_zero = (ms_q == 10'h000);
  wire fire_up = (st_q == rps_pkg::RPS_UP) & ms_zero & wake_request;
  wire fire_dn = (st_q == rps_pkg::RPS_DN) & ms_zero;
  wire [3:0] hit_up, hit_dn;
  genvar r;
  for (r = 0; r < 4; r++) begin : g_hit
    assign hit_up[r] = (up_order_q[2*r +: 2] == slot_q);
    assign hit_dn[r] = (dn_order_q[2*r +: 2] == slot_q);
  end
  wire [1:0] slot_nx = slot_q + 2'h1;

  // ****************************************
  // sequencer
  // ****************************************
  logic load;
  logic [9:0] load_ms;
  always_comb begin
    st_d = st_q;
    slot_d = slot_q;
    rail_d = rail_q;
    load = 1'b0;
    load_ms = 10'h000;
    case (st_q)
      rps_pkg::RPS_OFF: begin
        if (pg_rise & wake_request) begin
          st_d = rps_pkg::RPS_UP;
          slot_d = 2'h0;
          load = 1'b1;
          load_ms = dly_ms(1'b1, 2'h0, up_dly_q, dn_dly_q);
        end
      end
      rps_pkg::RPS_UP: begin
        if (!wake_request) begin
          st_d = rps_pkg::RPS_DN;
          slot_d = 2'h0;
          load = 1'b1;
          load_ms = dly_ms(1'b0, 2'h0, up_dly_q, dn_dly_q);
        end else if (fire_up) begin
          rail_d = rail_q | hit_up;
          if (slot_q == rps_pkg::LAST_SLOT) begin
            st_d = rps_pkg::RPS_ON;
          end else begin
            slot_d = slot_nx;
            load = 1'b1;
            load_ms = dly_ms(1'b1, slot_nx, up_dly_q, dn_dly_q);
          end
        end
      end
      rps_pkg::RPS_ON: begin
        if (!wake_request) begin
          st_d = rps_pkg::RPS_DN;
          slot_d = 2'h0;
          load = 1'b1;
          load_ms = dly_ms(1'b0, 2'h0, up_dly_q, dn_dly_q);
        end
      end
      rps_pkg::RPS_DN: begin
        if (fire_dn) begin
          rail_d = rail_q & ~hit_dn;
          if (slot_q == rps_pkg::LAST_SLOT) begin
            st_d = rps_pkg::RPS_OFF;
          end else begin
            slot_d = slot_nx;
            load = 1'b1;
            load_ms = dly_ms(1'b0, slot_nx, up_dly_q,
                             dn_dly_q);
          end
        end
      end
      default: begin
        st_d = rps_pkg::RPS_OFF;
        rail_d = 4'h0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= rps_pkg::RPS_OFF;
      slot_q <= 2'h0;
      rail_q <= 4'h0;
      strobe_q <= 4'h0;
      pg_q <= 1'b0;
    end else begin
      st_q <= st_d;
      slot_q <= slot_d;
      rail_q <= rail_d;
      strobe_q <= (fire_up | fire_dn) ? (4'h1 << slot_q) : 4'h0;
      pg_q <= negative_converter_power_good;
    end
  end

  // ms timer, prescaled from the core clock
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ms_q <= 10'h000;
      pre_q <= '0;
    end else if (load) begin
      ms_q <= load_ms;
      pre_q <= '0;
    end else if (!ms_zero) begin
      if (pre_q == PW'(CYC_PER_MS - 1)) begin
        pre_q <= '0;
        ms_q <= ms_q - 10'h001;
      end else begin
        pre_q <= pre_q + PW'(1);
      end
    end
  end

  assign negative_source_rail = rail_q[0];
  assign low_gate_rail = rail_q[1];
  assign positive_source_rail = rail_q[2];
  assign high_gate_rail = rail_q[3];
  assign sequence_slot_one = strobe_q[0];
  assign sequence_slot_two = strobe_q[1];
  assign sequence_slot_three = strobe_q[2];
  assign sequence_slot_four = strobe_q[3];

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  localparam logic [9:0] UP_STEP_MS_A = rps_pkg::UP_STEP_MS;

  sequence s_up_start;
    st_q == rps_pkg::RPS_OFF && pg_rise && wake_request;
  endsequence
  sequence s_dn_start;
    (st_q == rps_pkg::RPS_ON || st_q == rps_pkg::RPS_UP) && !wake_request;
  endsequence

  a_up_rail_slot: assert property (
    $rose(rail_q[3]) |-> $past(up_order_q[7:6]) == $past(slot_q))
    else $error("rail rose outside its up slot");
  a_dn_rail_slot: assert property (
    $fell(rail_q[0]) |-> $past(dn_order_q[1:0]) == $past(slot_q))
    else $error("rail fell outside its down slot");
  a_up_first_dly: assert property (
    s_up_start |=> ms_q ==
    10'(UP_STEP_MS_A * (10'($past(up_dly_q[1:0])) + 10'h001)))
    else $error("wrong first up delay");
  a_up_next_dly: assert property (
    fire_up && slot_q != 2'h3 |=> ms_q == 10'(UP_STEP_MS_A *
    (10'($past(up_dly_q[{slot_nx, 1'b0} +: 2])) + 10'h001)))
    else $error("wrong up spacing");
  a_dn_first_dly: assert property (
    s_dn_start |=> ms_q == ($past(dn_dly_q[1]) ? 10'h006 : 10'h003))
    else $error("wrong first down delay");
  a_dn_scaled_dly: assert property (
    fire_dn && slot_q == 2'h0 |=>
    ms_q == ((10'h006 << $past(dn_dly_q[3:2])) <<
    ($past(dn_dly_q[0]) ? 4 : 0)))
    else $error("wrong down spacing or scale");
  a_slot_ascend: assert property (
    slot_q != $past(slot_q) |->
    slot_q == $past(slot_q) + 2'h1 || slot_q == 2'h0)
    else $error("slot stepped out of order");
  a_shared_slot: assert property (
    fire_up |=> (rail_q & $past(hit_up)) == $past(hit_up))
    else $error("shared slot rails not switched together");
  a_no_early: assert property (
    !ms_zero |=> strobe_q == 4'h0)
    else $error("strobe before delay expired");
endmodule
`default_nettype wire

// ### bench/rail_power_sequencer_tb.sv
// self-checking bench for the four-rail power sequencer
`timescale 1ns/1ps
`default_nettype none
module rail_power_sequencer_tb;
  // ****************************************
  // signals
  // ****************************************
  localparam int CPM = 4;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic pg = 1'b0;
  logic wake = 1'b0;
  logic [3:0] rl;
  logic [3:0] stb;
  logic [31:0] rd;
  int failures = 0;
  int n_tests = 0;
  int cyc = 0;
  always #10 clk = ~clk;
  rps_sequencer #(.CYC_PER_MS(CPM)) i_dut (
    .clk(clk),
    .arst_n(arst_n),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hreadyout),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .negative_converter_power_good(pg),
    .wake_request(wake),
    .high_gate_rail(rl[3]),
    .positive_source_rail(rl[2]),
    .low_gate_rail(rl[1]),
    .negative_source_rail(rl[0]),
    .sequence_slot_one(stb[0]),
    .sequence_slot_two(stb[1]),
    .sequence_slot_three(stb[2]),
    .sequence_slot_four(stb[3])
  );
  // ****************************************
  // tasks
  // ****************************************
  task automatic test_done;
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] idx,
                      input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    do begin
      @(posedge clk);
    end while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    do begin
      @(posedge clk);
    end while (hreadyout !== 1'b1);
    r = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  task automatic rchk(input logic [7:0] idx, input logic [31:0] e);
    xfer(1'b0, idx, 32'h0, rd);
    chk("reg read", e, rd);
  endtask
  task automatic seq(input logic up, input logic [7:0] ord, input int ms [4]);
    int n;
    logic [3:0] er;
    logic [31:0] gap_ok;
    for (int s = 0; s < 4; s++) begin
      n = 0;
      do begin
        @(posedge clk);
        #1;
        n++;
        if ((stb & ~(4'h1 << s)) !== 4'h0) begin
          chk("strobe order", 32'h0, {28'h0, stb});
        end
      end while (stb[s] !== 1'b1 && n < 4000);
      gap_ok = 32'((n >= ms[s] * CPM) && (n <= ms[s] * CPM + 3));
      chk("gap", 32'h1, gap_ok);
      for (int i = 0; i < 4; i++) begin
        er[i] = up ? (ord[2*i +: 2] <= s) : (ord[2*i +: 2] > s);
      end
      chk("rails", {28'h0, er}, {28'h0, rl});
    end
  endtask
  // ****************************************
  // timeout
  // ****************************************
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      test_done;
    end
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    rchk(rps_pkg::IDX_UP_ORDER, 32'he4);
    rchk(rps_pkg::IDX_UP_DELAYS, {24'h0, rps_pkg::RST_UP_DELAYS});
    rchk(rps_pkg::IDX_DN_ORDER, 32'h1e);
    rchk(rps_pkg::IDX_DN_DELAYS, {24'h0, rps_pkg::RST_DN_DELAYS});
    rchk(8'h20, 32'h0);
    xfer(1'b1, 8'h20, 32'h5a, rd);
    rchk(8'h20, 32'h0);
    xfer(1'b1, rps_pkg::IDX_UP_ORDER, 32'hffffff1b, rd);
    rchk(rps_pkg::IDX_UP_ORDER, 32'h1b);
    xfer(1'b1, rps_pkg::IDX_UP_DELAYS, 32'h93, rd);
    rchk(rps_pkg::IDX_UP_DELAYS, 32'h93);
    xfer(1'b1, rps_pkg::IDX_DN_ORDER, 32'he4, rd);
    xfer(1'b1, rps_pkg::IDX_DN_DELAYS, 32'h4e, rd);
    rchk(rps_pkg::IDX_DN_DELAYS, 32'h4e);
    @(posedge clk);
    wake <= 1'b1;
    pg <= 1'b1;
    seq(1'b1, 8'h1b, '{12, 3, 6, 9});
    rchk(rps_pkg::IDX_STATUS, 32'h0000043f);
    repeat (5) @(posedge clk);
    wake <= 1'b0;
    seq(1'b0, 8'he4, '{6, 48, 6, 12});
    repeat (5) @(posedge clk);
    pg <= 1'b0;
    xfer(1'b1, rps_pkg::IDX_UP_ORDER, 32'h50, rd);
    xfer(1'b1, rps_pkg::IDX_DN_ORDER, 32'hf0, rd);
    xfer(1'b1, rps_pkg::IDX_DN_DELAYS, 32'h19, rd);
    @(posedge clk);
    wake <= 1'b1;
    pg <= 1'b1;
    seq(1'b1, 8'h50, '{12, 3, 6, 9});
    repeat (5) @(posedge clk);
    wake <= 1'b0;
    seq(1'b0, 8'hf0, '{3, 384, 192, 96});
    test_done;
  end
endmodule
`default_nettype wire
